// ===== design/sxpv_core.sv
// Serial program/verify command interpreter, device side.
// Assumes a memory array on ref_clk that answers a read in the same
// cycle as mem_valid, and a programmer clocking the link pins.
`timescale 1ns/1ps
`default_nettype none
`include "sxpv_cfg.svh"

module sxpv_core #(
    parameter int unsigned INT_PROG_CYC = `SXPV_INTERNAL_PROGRAM_TIME_US * `SXPV_CLK_MHZ,
    parameter int unsigned BULK_ERA_CYC = `SXPV_BULK_ERASE_TIME_US * `SXPV_CLK_MHZ,
    parameter int unsigned ROW_ERA_CYC  = `SXPV_TERAR_US * `SXPV_CLK_MHZ
) (
    // Core clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    // Programming mode level, asynchronous
    input  wire logic                    prog_mode_en,
    // Serial link
    input  wire logic                    serial_clock_pin,
    input  wire logic                    serial_data_pin_in,
    output logic                         serial_data_pin_out,
    output logic                         serial_data_pin_oe_b,
    // Memory array
    output logic                         mem_valid,
    output sxpv_pkg::sxpv_req_t          mem_cmd,
    input  wire logic [`SXPV_WORD_W-1:0] mem_rdata,
    input  wire logic [`SXPV_WORD_W-1:0] config_word1,
    output logic                         prog_busy
);
    import sxpv_pkg::*;

    function automatic logic [`SXPV_ADDR_W-1:0] addr_inc(
        input logic [`SXPV_ADDR_W-1:0] a);
        if (a == `SXPV_A_PM_TOP)
            return `SXPV_A_ZERO;
        else if (a == `SXPV_A_TOP)
            return `SXPV_A_CFG;
        return a + `SXPV_A_ONE;
    endfunction

    function automatic logic is_cfg_cal(input logic [`SXPV_ADDR_W-1:0] a);
        return (a >= `SXPV_A_CW1) && (a <= `SXPV_A_CAL_END);
    endfunction

    // ---------------------------------------------------------------
    // Link domain, falling edge of the serial clock; read data out on the rising edge
    // ---------------------------------------------------------------
    logic                     run_s1, ser_run, link_run;
    sxpv_lst_t                st, next_st;
    logic [4:0]               cnt, next_cnt;
    logic [15:0]              sh, next_sh;
    logic [`SXPV_ADDR_W-1:0]  addr, next_addr;
    logic [`SXPV_WORD_W-1:0]  latch, next_latch, rd_word;
    sxpv_req_t                req, next_req;
    logic                     tgl, next_tgl, drive, next_drive;
    logic                     cmd_done, next_out;
    logic [4:0]               code;

    assign cmd_done = (st == SXPV_L_CMD) && (cnt == `SXPV_CMD_LAST);
    assign code     = sh[15:11];

    always_ff @(negedge serial_clock_pin) begin
        run_s1  <= link_run;
        ser_run <= run_s1;
    end

    always_comb begin
        logic     iss;
        sxpv_op_t iop;
        iss        = 1'b0;
        iop        = SXPV_OP_READ;
        next_st    = st;
        next_cnt   = cnt + `SXPV_CNT_ONE;
        next_sh    = {serial_data_pin_in, sh[15:1]};
        next_addr  = addr;
        next_latch = latch;
        next_req   = req;
        next_tgl   = tgl;
        next_drive = drive;
        case (st)
            SXPV_L_CMD: begin
                if (cmd_done) begin
                    next_cnt = '0;
                    case (code)
                        `SXPV_C_LDCFG: begin
                            next_addr = `SXPV_A_CFG;
                            next_st   = SXPV_L_DIN;
                        end
                        `SXPV_C_LDDAT: next_st = SXPV_L_DIN;
                        `SXPV_C_READ: begin
                            next_st = SXPV_L_DOUT;
                            iss     = 1'b1;
                            iop     = SXPV_OP_READ;
                        end
                        `SXPV_C_INC: next_addr = addr_inc(addr);
                        `SXPV_C_RSTA: next_addr = `SXPV_A_ZERO;
                        `SXPV_C_BIPT: begin
                            iss = 1'b1;
                            iop = SXPV_OP_WRITE_INT;
                        end
                        `SXPV_C_BEPT: begin
                            iss = 1'b1;
                            iop = SXPV_OP_WRITE_EXT;
                        end
                        `SXPV_C_EEPT: begin
                            iss = 1'b1;
                            iop = SXPV_OP_EXT_END;
                        end
                        `SXPV_C_BULK: begin
                            iss = 1'b1;
                            if (addr >= `SXPV_A_CFG &&
                                addr <= `SXPV_A_ID_END)
                                iop = SXPV_OP_BULK_ALL;
                            else
                                iop = SXPV_OP_BULK_PM;
                        end
                        `SXPV_C_ROW: begin
                            iss = (addr < `SXPV_A_CFG);
                            iop = SXPV_OP_ROW;
                        end
                        default: ;
                    endcase
                end
            end
            SXPV_L_DIN: begin
                if (cnt == `SXPV_DATA_LAST) begin
                    next_latch = sh[15:2];
                    next_st    = SXPV_L_CMD;
                    next_cnt   = '0;
                end
            end
            SXPV_L_DOUT: begin
                if (cnt == '0)
                    next_drive = 1'b1;
                if (cnt == `SXPV_DATA_LAST) begin
                    next_drive = 1'b0;
                    next_st    = SXPV_L_CMD;
                    next_cnt   = '0;
                end
            end
            default: begin
                next_st  = SXPV_L_CMD;
                next_cnt = '0;
            end
        endcase
        if (iss) begin
            next_req = '{op: iop, addr: addr, data: latch};
            next_tgl = ~tgl;
        end
    end

    always_ff @(negedge serial_clock_pin) begin
        if (!ser_run) begin
            st    <= SXPV_L_CMD;
            cnt   <= '0;
            sh    <= '0;
            addr  <= `SXPV_A_ZERO;
            latch <= '0;
            req   <= '0;
            tgl   <= 1'b0;
            drive <= 1'b0;
        end else begin
            st    <= next_st;
            cnt   <= next_cnt;
            sh    <= next_sh;
            addr  <= next_addr;
            latch <= next_latch;
            req   <= next_req;
            tgl   <= next_tgl;
            drive <= next_drive;
        end
    end

    // Read bits leave on rising edges; rd_word settled during the gap
    always_comb begin
        next_out = 1'b0;
        if (st == SXPV_L_DOUT && cnt >= `SXPV_CNT_ONE &&
            cnt <= `SXPV_DBIT_LAST)
            next_out = rd_word[4'(cnt - `SXPV_CNT_ONE)];
    end

    always_ff @(posedge serial_clock_pin) begin
        if (!ser_run)
            serial_data_pin_out <= 1'b0;
        else
            serial_data_pin_out <= next_out;
    end

    assign serial_data_pin_oe_b = ~drive;

    // ---------------------------------------------------------------
    // Core domain: request crossing, memory port, operation timer
    // ---------------------------------------------------------------
    logic                     md_s1, md_s2, tg_s1, tg_s2, tg_s3;
    logic                     new_req, rd_pend, next_rd_pend, ext_on;
    logic                     next_ext_on, next_busy, next_valid;
    logic                     next_link_run;
    logic [`SXPV_TMR_W-1:0]   tmr, next_tmr;
    logic [`SXPV_WORD_W-1:0]  next_rd_word;
    sxpv_req_t                next_cmd;

    assign new_req = tg_s2 ^ tg_s3;

    always_ff @(posedge ref_clk) begin
        md_s1 <= prog_mode_en;
        md_s2 <= md_s1;
        tg_s1 <= tgl;
        tg_s2 <= tg_s1;
        tg_s3 <= tg_s2;
    end

    always_comb begin
        next_link_run = md_s2;
        next_valid    = 1'b0;
        next_cmd      = mem_cmd;
        next_rd_pend  = 1'b0;
        next_rd_word  = rd_word;
        next_busy     = prog_busy;
        next_ext_on   = ext_on;
        next_tmr      = tmr;
        if (rd_pend) begin
            if (!config_word1[`SXPV_CP_BIT] && mem_cmd.addr < `SXPV_A_CFG)
                next_rd_word = '0;
            else
                next_rd_word = mem_rdata;
        end
        if (prog_busy && !ext_on) begin
            if (tmr == '0)
                next_busy = 1'b0;
            else
                next_tmr = tmr - 1'b1;
        end
        // A link reset flips the toggle too; drop that while the link is held
        if (new_req && link_run) begin
            next_cmd = req;
            case (req.op)
                SXPV_OP_READ: begin
                    next_valid   = 1'b1;
                    next_rd_pend = 1'b1;
                end
                SXPV_OP_WRITE_INT: begin
                    next_valid = 1'b1;
                    next_busy  = 1'b1;
                    next_tmr   = `SXPV_TMR_W'(INT_PROG_CYC - 1);
                end
                SXPV_OP_WRITE_EXT: begin
                    next_valid  = !is_cfg_cal(req.addr);
                    next_busy   = 1'b1;
                    next_ext_on = 1'b1;
                end
                SXPV_OP_EXT_END: begin
                    next_valid  = ext_on;
                    next_busy   = 1'b0;
                    next_ext_on = 1'b0;
                end
                SXPV_OP_BULK_PM, SXPV_OP_BULK_ALL: begin
                    next_valid = 1'b1;
                    next_busy  = 1'b1;
                    next_tmr   = `SXPV_TMR_W'(BULK_ERA_CYC - 1);
                end
                SXPV_OP_ROW: begin
                    next_valid = 1'b1;
                    next_busy  = 1'b1;
                    next_tmr   = `SXPV_TMR_W'(ROW_ERA_CYC - 1);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            link_run  <= 1'b0;
            mem_valid <= 1'b0;
            mem_cmd   <= '0;
            rd_pend   <= 1'b0;
            rd_word   <= '0;
            prog_busy <= 1'b0;
            ext_on    <= 1'b0;
            tmr       <= '0;
        end else begin
            link_run  <= next_link_run;
            mem_valid <= next_valid;
            mem_cmd   <= next_cmd;
            rd_pend   <= next_rd_pend;
            rd_word   <= next_rd_word;
            prog_busy <= next_busy;
            ext_on    <= next_ext_on;
            tmr       <= next_tmr;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence data_frame_s;
        (st == SXPV_L_DIN) [*8] ##1 (st == SXPV_L_DIN) [*8];
    endsequence

    inc_wrap_low_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        cmd_done && code == `SXPV_C_INC && addr == `SXPV_A_PM_TOP
        |=> addr == `SXPV_A_ZERO) else $error("bad wrap at 7fff");
    inc_wrap_high_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        cmd_done && code == `SXPV_C_INC && addr == `SXPV_A_TOP
        |=> addr == `SXPV_A_CFG) else $error("bad wrap at ffff");
    addr_reset_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        cmd_done && code == `SXPV_C_RSTA |=> addr == `SXPV_A_ZERO)
        else $error("reset address failed");
    load_cfg_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        cmd_done && code == `SXPV_C_LDCFG
        |=> addr == `SXPV_A_CFG && st == SXPV_L_DIN)
        else $error("load config failed");
    data_len_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        $rose(st == SXPV_L_DIN) |-> data_frame_s ##1 st == SXPV_L_CMD)
        else $error("data phase not 16 clocks");
    read_drive_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        st == SXPV_L_DOUT && cnt == '0
        |=> !serial_data_pin_oe_b ##15 serial_data_pin_oe_b)
        else $error("read drive window wrong");
    bulk_scope_a: assert property (@(negedge serial_clock_pin)
        disable iff (!ser_run)
        cmd_done && code == `SXPV_C_BULK && addr >= `SXPV_A_CFG &&
        addr <= `SXPV_A_ID_END |=> req.op == SXPV_OP_BULK_ALL)
        else $error("bulk erase scope wrong");
    protect_read_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        rd_pend && !config_word1[`SXPV_CP_BIT] &&
        mem_cmd.addr < `SXPV_A_CFG |=> rd_word == '0)
        else $error("protected read not zero");
    ext_cfg_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        link_run && new_req && req.op == SXPV_OP_WRITE_EXT &&
        is_cfg_cal(req.addr)
        |=> !mem_valid && prog_busy) else $error("ext write to config");
    row_cal_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        mem_valid && mem_cmd.op == SXPV_OP_ROW
        |-> mem_cmd.addr < `SXPV_A_CFG) else $error("row erase in cfg");
    busy_hold_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        prog_busy && !ext_on && tmr != '0 && !new_req |=> prog_busy)
        else $error("busy ended early");
endmodule
`default_nettype wire

// ===== design/sxpv_cfg.svh
// Constants of the serial program/verify command interpreter.
// Assumes inclusion by bare name from package and design files.
`ifndef SXPV_CFG_SVH
`define SXPV_CFG_SVH
`define SXPV_ADDR_W     16
`define SXPV_WORD_W     14
// Command codes, top command bit dropped
`define SXPV_C_LDCFG    5'h00
`define SXPV_C_LDDAT    5'h02
`define SXPV_C_READ     5'h04
`define SXPV_C_INC      5'h06
`define SXPV_C_RSTA     5'h16
`define SXPV_C_BIPT     5'h08
`define SXPV_C_BEPT     5'h18
`define SXPV_C_EEPT     5'h0a
`define SXPV_C_BULK     5'h09
`define SXPV_C_ROW      5'h11
// Address map
`define SXPV_A_ZERO     16'h0000
`define SXPV_A_PM_TOP   16'h7fff
`define SXPV_A_CFG      16'h8000
`define SXPV_A_CW1      16'h8007
`define SXPV_A_ID_END   16'h8008
`define SXPV_A_CAL_END  16'h800a
`define SXPV_A_TOP      16'hffff
`define SXPV_A_ONE      16'h0001
// Frame counts on the serial link
`define SXPV_CNT_ONE    5'h01
`define SXPV_CMD_LAST   5'h05
`define SXPV_DBIT_LAST  5'h0e
`define SXPV_DATA_LAST  5'h0f
// Code protect position in configuration word 1
`define SXPV_CP_BIT     7
// Timing, core clock rate and operation times
`define SXPV_CLK_MHZ    250
`define SXPV_INTERNAL_PROGRAM_TIME_US   5
`define SXPV_BULK_ERASE_TIME_US   10000
`define SXPV_TERAR_US   5
`define SXPV_TMR_W      24
`endif

// ===== design/sxpv_pkg.sv
// Types shared by the serial program/verify interpreter.
// Assumes sxpv_cfg.svh on the include path.
`include "sxpv_cfg.svh"
package sxpv_pkg;
    typedef enum logic [2:0] {
        SXPV_OP_READ, SXPV_OP_WRITE_INT, SXPV_OP_WRITE_EXT,
        SXPV_OP_EXT_END, SXPV_OP_BULK_PM, SXPV_OP_BULK_ALL, SXPV_OP_ROW
    } sxpv_op_t;
    typedef struct packed {
        sxpv_op_t                  op;
        logic [`SXPV_ADDR_W-1:0]   addr;
        logic [`SXPV_WORD_W-1:0]   data;
    } sxpv_req_t;
    typedef enum logic [1:0] {
        SXPV_L_CMD, SXPV_L_DIN, SXPV_L_DOUT
    } sxpv_lst_t;
endpackage

// ===== test/sxpv_prog_model.sv
// Programmer model: clocks commands and data frames into the link.
// Assumes the bench resolves the data line and calls these tasks.
`timescale 1ns/1ps
`default_nettype none
module sxpv_prog_model (
    // Link clock and data drive
    output logic      serial_clock_pin,
    output logic      host_bit,
    output logic      host_drv,
    // Resolved line and device drive
    input  wire logic line_level,
    input  wire logic dev_drv
);
    // --------------------------------
    // Bit timing, 32 ns link period
    // --------------------------------
    localparam time GAP = 200ns;

    initial begin
        serial_clock_pin = 1'b0;
        host_bit         = 1'b0;
        host_drv         = 1'b1;
    end

    // Data moves 4 ns after the falling edge; clock idles low
    task automatic clk_bit(input logic b);
        #4 host_bit = b;
        #12 serial_clock_pin = 1'b1;
        #16 serial_clock_pin = 1'b0;
    endtask

    // Gap also covers the short timed operations
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) begin
            clk_bit(c[i]);
        end
        #GAP;
    endtask

    task automatic wr_word(input logic [13:0] w);
        clk_bit(1'b0);
        for (int i = 0; i < 14; i++) begin
            clk_bit(w[i]);
        end
        clk_bit(1'b0);
        #GAP;
    endtask

    // Samples just before each falling edge; ok tracks pin ownership
    task automatic rd_word(output logic [13:0] w, output logic ok);
        ok       = 1'b1;
        w        = 14'h0000;
        host_drv = 1'b0;
        for (int f = 1; f <= 16; f++) begin
            #16 serial_clock_pin = 1'b1;
            #12;
            if (f >= 2) ok &= dev_drv;
            if (f >= 2 && f <= 15) w[f-2] = line_level;
            #4 serial_clock_pin = 1'b0;
        end
        #16;
        ok &= !dev_drv;
        host_drv = 1'b1;
        #GAP;
    endtask
endmodule
`default_nettype wire

// ===== test/sxpv_core_tb_top.sv
// Bench for the serial program/verify interpreter.
// Assumes the package, the design and the programmer model compiled first.
`timescale 1ns/1ps
`default_nettype none
module sxpv_core_tb_top;
    import sxpv_pkg::*;
    // --------------------------------
    // Signals and instances
    // --------------------------------
    localparam int unsigned CYC = 20;
    logic        ref_clk      = 1'b0;
    logic        rst_b        = 1'b0;
    logic        prog_mode_en = 1'b0;
    logic [13:0] config_word1 = 14'h3fff;
    logic [13:0] mem_rdata    = 14'h0000;
    logic        idle_pat     = 1'b0;
    logic        serial_clock_pin, host_bit, host_drv;
    logic        data_out, data_oe_b, mem_valid, prog_busy;
    wire         line;
    sxpv_req_t   mem_cmd;
    sxpv_req_t   seen;
    int unsigned n_ops = 0, busy_len = 0, cyc = 0;
    int unsigned err_total = 0, checks = 0;

    always #2 ref_clk = ~ref_clk;
    // Released line shows a changing pattern, not its last value
    assign line = !data_oe_b ? data_out : (host_drv ? host_bit : idle_pat);

    sxpv_core #(.INT_PROG_CYC(CYC), .BULK_ERA_CYC(CYC), .ROW_ERA_CYC(CYC))
    i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .prog_mode_en(prog_mode_en),
        .serial_clock_pin(serial_clock_pin), .serial_data_pin_in(line),
        .serial_data_pin_out(data_out), .serial_data_pin_oe_b(data_oe_b),
        .mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
        .config_word1(config_word1), .prog_busy(prog_busy)
    );
    sxpv_prog_model p (
        .serial_clock_pin(serial_clock_pin), .host_bit(host_bit),
        .host_drv(host_drv), .line_level(line), .dev_drv(!data_oe_b)
    );

    // --------------------------------
    // Memory model, monitor, timeout
    // --------------------------------
    always @(posedge ref_clk) begin
        idle_pat <= ~idle_pat;
        cyc      <= cyc + 1;
        if (prog_busy) busy_len <= busy_len + 1;
        if (mem_valid) begin
            seen  <= mem_cmd;
            n_ops <= n_ops + 1;
            // Array model: reads return the last internally timed word
            if (mem_cmd.op == SXPV_OP_WRITE_INT) begin
                mem_rdata <= mem_cmd.data;
            end
        end
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end

    // --------------------------------
    // Checking helpers
    // --------------------------------
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic expect_op(input sxpv_op_t op, input logic [15:0] a,
                             input int unsigned n0);
        chk("op count", n0 + 1, n_ops);
        chk("op code", {29'h0, op}, {29'h0, seen.op});
        chk("op addr", {16'h0, a}, {16'h0, seen.addr});
    endtask

    task automatic rd_expect(input string nm, input logic [13:0] exp);
        logic [13:0] w;
        logic        ok;
        p.cmd(6'h04);
        p.rd_word(w, ok);
        chk("read pin drive", 32'h1, {31'h0, ok});
        chk(nm, {18'h0, exp}, {18'h0, w});
    endtask

    task automatic set_cw1(input logic [13:0] v);
        @(posedge ref_clk);
        #1 config_word1 = v;
    endtask

    // Mode drop resets the link; exactly two clocks after re-entry pass
    // the run flag, so the next command frame starts aligned
    task automatic link_restart;
        @(posedge ref_clk);
        #1 prog_mode_en = 1'b0;
        repeat (4) p.clk_bit(1'b0);
        @(posedge ref_clk);
        #1 prog_mode_en = 1'b1;
        repeat (2) p.clk_bit(1'b0);
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_write_int;
        int unsigned n0, b0;
        p.cmd(6'h22);
        p.wr_word(14'h2abc);
        n0 = n_ops;
        b0 = busy_len;
        p.cmd(6'h08);
        expect_op(SXPV_OP_WRITE_INT, 16'h0000, n0);
        chk("write data", 32'h2abc, {18'h0, seen.data});
        b0 = busy_len - b0;
        chk("int busy", 32'h1, {31'h0, b0 >= CYC && b0 <= CYC + 1});
        p.cmd(6'h06);
        p.cmd(6'h02);
        p.wr_word(14'h1234);
        n0 = n_ops;
        p.cmd(6'h08);
        expect_op(SXPV_OP_WRITE_INT, 16'h0001, n0);
    endtask

    task automatic t_read;
        rd_expect("read word", 14'h1234);
        set_cw1(14'h3f7f);
        rd_expect("protected read", 14'h0000);
    endtask

    task automatic t_cfg;
        int unsigned n0;
        p.cmd(6'h00);
        p.wr_word(14'h3f7f);
        n0 = n_ops;
        p.cmd(6'h08);
        expect_op(SXPV_OP_WRITE_INT, 16'h8000, n0);
        chk("cfg data", 32'h3f7f, {18'h0, seen.data});
        for (int i = 0; i < 7; i++) begin
            p.cmd(6'h06);
        end
        p.cmd(6'h02);
        p.wr_word(14'h0123);
        n0 = n_ops;
        p.cmd(6'h18);
        chk("cfg ext write", n0, n_ops);
        chk("cfg ext busy", 32'h1, {31'h0, prog_busy});
        p.cmd(6'h0a);
        #400;
        chk("cfg ext idle", 32'h0, {31'h0, prog_busy});
        p.cmd(6'h06);
        rd_expect("cfg read", 14'h3f7f);
        set_cw1(14'h0080);
        n0 = n_ops;
        p.cmd(6'h09);
        expect_op(SXPV_OP_BULK_ALL, 16'h8008, n0);
        n0 = n_ops;
        p.cmd(6'h11);
        chk("row in cfg", n0, n_ops);
    endtask

    task automatic t_rsta;
        int unsigned n0;
        p.cmd(6'h16);
        n0 = n_ops;
        p.cmd(6'h09);
        expect_op(SXPV_OP_BULK_PM, 16'h0000, n0);
        n0 = n_ops;
        p.cmd(6'h11);
        expect_op(SXPV_OP_ROW, 16'h0000, n0);
        p.cmd(6'h02);
        p.wr_word(14'h0f0f);
        n0 = n_ops;
        p.cmd(6'h18);
        expect_op(SXPV_OP_WRITE_EXT, 16'h0000, n0);
        chk("ext busy", 32'h1, {31'h0, prog_busy});
        n0 = n_ops;
        p.cmd(6'h0a);
        chk("end count", n0 + 1, n_ops);
        chk("end code", {29'h0, SXPV_OP_EXT_END}, {29'h0, seen.op});
        #400;
        chk("ext idle", 32'h0, {31'h0, prog_busy});
    endtask

    task automatic t_mode;
        int unsigned n0;
        p.cmd(6'h00);
        p.wr_word(14'h2a80);
        p.cmd(6'h08);
        p.cmd(6'h02);
        p.wr_word(14'h0155);
        p.cmd(6'h18);
        chk("open ext busy", 32'h1, {31'h0, prog_busy});
        @(posedge ref_clk);
        #1 rst_b = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("reset busy", 32'h0, {31'h0, prog_busy});
        chk("reset valid", 32'h0, {31'h0, mem_valid});
        rst_b = 1'b1;
        n0 = n_ops;
        link_restart();
        chk("mode drop ops", n0, n_ops);
        rd_expect("re-entry read", 14'h2a80);
        expect_op(SXPV_OP_READ, 16'h0000, n0);
    endtask

    task automatic end_of_test;
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        link_restart();
        t_write_int();
        t_read();
        t_cfg();
        t_rsta();
        t_mode();
        end_of_test();
    end
endmodule
`default_nettype wire
